// File: design/scc_pkg.sv
// Package: register map, field positions and enumerations of the serial config block
package scc_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_MAIN_CTRL = 6'h00;
    localparam logic [5:0] OFS_SPI_CTRL  = 6'h04;
    localparam logic [5:0] OFS_TX_CTRL   = 6'h08;
    localparam logic [5:0] OFS_RX_CTRL   = 6'h0C;
    localparam logic [5:0] OFS_TXQ_CTRL  = 6'h10;
    localparam logic [5:0] OFS_RXQ_CTRL  = 6'h14;
    localparam logic [5:0] OFS_STATUS    = 6'h18;
    localparam logic [5:0] OFS_IRQ_STAT  = 6'h1C;
    localparam logic [5:0] OFS_IRQ_MASK  = 6'h20;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MAIN_EN_BIT    = 31;
    localparam int MAIN_SEL_LO    = 24;
    localparam int SPI_ROLE_BIT   = 31;
    localparam int SPI_SUB_LO     = 4;
    localparam int FRM_MSB_BIT    = 8;
    localparam int FRM_MEDIAN_BIT = 9;
    localparam int Q_CLEAR_BIT    = 16;
    localparam int Q_FREEZE_BIT   = 17;
    localparam int Q_DEPTH        = 8;
    localparam int Q_AW           = 3;
    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [31:0] MAIN_RST  = 32'h0000_0000;
    localparam logic [31:0] SPI_RST   = 32'h0000_0000;
    localparam logic [31:0] FRM_RST   = 32'h0000_0107;
    localparam logic [31:0] Q_RST     = 32'h0000_0000;
    localparam logic [31:0] MAIN_MASK = 32'h8300_0000;
    localparam logic [31:0] SPI_MASK  = 32'h8000_0030;
    localparam logic [31:0] TXF_MASK  = 32'h0000_010F;
    localparam logic [31:0] RXF_MASK  = 32'h0000_030F;
    localparam logic [31:0] Q_MASK    = 32'h0003_000F;
    localparam logic [3:0]  WIDTH_MIN = 4'h3;
    localparam logic [1:0]  IRQ_BITS  = 2'h3;
    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SEL_I2C = 2'h0, SEL_SPI = 2'h1, SEL_UART = 2'h2,
                              SEL_RSVD = 2'h3} scc_sel_t;
    typedef enum logic [1:0] {SUB_FMT_A = 2'h0, SUB_FMT_B = 2'h1, SUB_FMT_C = 2'h2,
                              SUB_RSVD = 2'h3} scc_sub_t;
    typedef enum logic [1:0] {ST_OFF = 2'h0, ST_INIT = 2'h1, ST_RUN = 2'h3} scc_state_t;
endpackage

// File: design/scc_top.sv
// Configuration, enable control and trigger logic of the serial comm block
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
// Functional notes
// - Addressable-memory variant is allowed only in slave role.
// - Main, protocol and frame control writes while enabled take effect only after re-enable.
// - Re-enable re-initializes state and empties both queues.
// - Main selector [25:24]: 00 I2C, 01 SPI, 10 UART, 11 reserved.
// - Main control bit 31 enables the block.
// - Submode [5:4] picks frame format; 11 reserved.
// - Protocol control bit 31: 0 slave, 1 master.
// - Frame length is width field plus one, field 3 to 15.
// - Frame bit 8: 1 MSB first, 0 LSB first.
// - Receive bit 9 enables three-tap majority filter on inputs.
// - Transmit trigger below level, receive trigger above level.
// - Clear bit 16 empties its queue and shift register.
// - Freeze bit 17 blocks pushes, pops and pointer movement.
// - All control and status registers are 32 bits wide.
module scc_top
    import scc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        tx_push,
    input  wire logic [15:0] tx_push_data,
    input  wire logic        tx_pop,
    input  wire logic        rx_push,
    input  wire logic [15:0] rx_push_data,
    input  wire logic        rx_pop,
    input  wire logic        line_in,
    output logic             line_filt,
    output logic             active_spi,
    output logic             role_master,
    output logic [1:0]       sub_format,
    output logic [3:0]       tx_bits_m1,
    output logic [3:0]       rx_bits_m1,
    output logic             tx_msb_first,
    output logic             rx_msb_first,
    output logic             tx_shift_clr,
    output logic             rx_shift_clr,
    output logic             tx_trigger,
    output logic             rx_trigger,
    output logic             irq
);
    // ------------------------------------------------------------
    // Software view registers
    // ------------------------------------------------------------
    logic [31:0] main_r, spi_r, txf_r, rxf_r, txq_r, rxq_r;
    logic [31:0] spi_act_r, txf_act_r, rxf_act_r, main_act_r;
    logic [1:0]  irq_stat_r, irq_mask_r;
    logic [1:0]  irq_set;
    scc_state_t  state_r;
    logic        wr_acc, rd_acc, hit;
    logic [31:0] rd_nxt;
    logic [31:0] bmask;
    logic [5:0]  ofs;

    // Bit 5 is decoded too, else 0x20 and above would alias low registers
    assign ofs    = wb_adr_i[5:0];
    assign bmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign hit    = (wb_adr_i[31:6] == 26'h0) && (wb_adr_i[1:0] == 2'h0) && (ofs <= OFS_IRQ_MASK);
    assign wr_acc = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_we_i && hit;
    assign rd_acc = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m);
        merge = ((old & ~bmask) | (wb_dat_i & bmask)) & m;
    endfunction

    // Width field below minimum is clamped up to keep frames legal
    function automatic logic [31:0] frm_fix(input logic [31:0] v);
        frm_fix = v;
        if (v[3:0] < WIDTH_MIN)
        begin
            frm_fix[3:0] = WIDTH_MIN;
        end
    endfunction

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            main_r <= MAIN_RST;
            spi_r  <= SPI_RST;
            txf_r  <= FRM_RST;
            rxf_r  <= FRM_RST;
            txq_r  <= Q_RST;
            rxq_r  <= Q_RST;
            irq_mask_r <= 2'h0;
        end
        else if (wr_acc)
        begin
            case (ofs)
                // No addressable-memory bit is kept, so master role never meets it
                OFS_MAIN_CTRL: main_r <= merge(main_r, MAIN_MASK);
                OFS_SPI_CTRL:  spi_r  <= merge(spi_r, SPI_MASK);
                OFS_TX_CTRL:   txf_r  <= frm_fix(merge(txf_r, TXF_MASK));
                OFS_RX_CTRL:   rxf_r  <= frm_fix(merge(rxf_r, RXF_MASK));
                OFS_TXQ_CTRL:  txq_r  <= merge(txq_r, Q_MASK);
                OFS_RXQ_CTRL:  rxq_r  <= merge(rxq_r, Q_MASK);
                OFS_IRQ_MASK:  irq_mask_r <= wb_sel_i[0] ? wb_dat_i[1:0] : irq_mask_r;
                default:       ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Enable sequencing: controls latched only on a rising enable
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_r <= ST_OFF;
        end
        else
        begin
            case (state_r)
                ST_OFF:  state_r <= main_r[MAIN_EN_BIT] ? ST_INIT : ST_OFF;
                ST_INIT: state_r <= main_r[MAIN_EN_BIT] ? ST_RUN : ST_OFF;
                ST_RUN:  state_r <= main_r[MAIN_EN_BIT] ? ST_RUN : ST_OFF;
                default: state_r <= ST_OFF;
            endcase
        end
    end

    // Active copies freeze while running so writes wait for re-enable
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            main_act_r <= MAIN_RST;
            spi_act_r  <= SPI_RST;
            txf_act_r  <= FRM_RST;
            rxf_act_r  <= FRM_RST;
        end
        else if (state_r == ST_OFF && main_r[MAIN_EN_BIT])
        begin
            main_act_r <= main_r;
            spi_act_r  <= spi_r;
            txf_act_r  <= txf_r;
            rxf_act_r  <= rxf_r;
        end
    end

    // ------------------------------------------------------------
    // Queue occupancy per direction
    // ------------------------------------------------------------
    logic [Q_AW:0] q_cnt [2];
    logic [1:0]    q_clr, q_frz, q_push, q_pop;
    logic [3:0]    q_lvl [2];
    logic          init_clr;

    assign init_clr  = (state_r == ST_INIT);
    assign q_clr     = {rxq_r[Q_CLEAR_BIT], txq_r[Q_CLEAR_BIT]};
    assign q_frz     = {rxq_r[Q_FREEZE_BIT], txq_r[Q_FREEZE_BIT]};
    assign q_push    = {rx_push, tx_push};
    assign q_pop     = {rx_pop, tx_pop};
    assign q_lvl[0]  = txq_r[3:0];
    assign q_lvl[1]  = rxq_r[3:0];

    // Data words are handled by the shifting logic; only occupancy kept here
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_q
            logic do_push, do_pop;
            assign do_push = q_push[g] && !q_frz[g] && (q_cnt[g] != (Q_AW+1)'(Q_DEPTH));
            assign do_pop  = q_pop[g] && !q_frz[g] && (q_cnt[g] != '0);
            always_ff @(posedge clk_sys)
            begin
                if (srst || init_clr || q_clr[g] || state_r == ST_OFF)
                begin
                    q_cnt[g] <= '0;
                end
                else if (do_push && !do_pop)
                begin
                    q_cnt[g] <= q_cnt[g] + 1'b1;
                end
                else if (do_pop && !do_push)
                begin
                    q_cnt[g] <= q_cnt[g] - 1'b1;
                end
            end
        end
    endgenerate

    logic tx_trig_nxt, rx_trig_nxt;
    assign tx_trig_nxt = (state_r == ST_RUN) && ({1'b0, q_cnt[0]} < {1'b0, q_lvl[0]});
    assign rx_trig_nxt = (state_r == ST_RUN) && ({1'b0, q_cnt[1]} > {1'b0, q_lvl[1]});
    assign irq_set     = {rx_trig_nxt, tx_trig_nxt};

    // ------------------------------------------------------------
    // Input majority filter
    // ------------------------------------------------------------
    logic [1:0] sync_r;
    logic [2:0] tap_r;
    logic       maj3;
    // A lone one-cycle glitch never wins the vote
    assign maj3 = (tap_r[0] & tap_r[1]) | (tap_r[1] & tap_r[2]) | (tap_r[0] & tap_r[2]);
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sync_r <= 2'h0;
            tap_r  <= 3'h0;
        end
        else
        begin
            sync_r <= {sync_r[0], line_in};
            tap_r  <= {tap_r[1:0], sync_r[1]};
        end
    end

    // ------------------------------------------------------------
    // Outputs and interrupt status
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            line_filt    <= 1'b0;
            active_spi   <= 1'b0;
            role_master  <= 1'b0;
            sub_format   <= SUB_FMT_A;
            tx_bits_m1   <= WIDTH_MIN;
            rx_bits_m1   <= WIDTH_MIN;
            tx_msb_first <= 1'b0;
            rx_msb_first <= 1'b0;
        end
        else
        begin
            // Filter adds one cycle of latency, hence higher oversampling
            line_filt <= rxf_act_r[FRM_MEDIAN_BIT] ? maj3 : tap_r[0];
            active_spi   <= (state_r == ST_RUN)
                            && (main_act_r[MAIN_SEL_LO +: 2] == SEL_SPI);
            role_master  <= spi_act_r[SPI_ROLE_BIT];
            sub_format   <= spi_act_r[SPI_SUB_LO +: 2];
            tx_bits_m1   <= txf_act_r[3:0];
            rx_bits_m1   <= rxf_act_r[3:0];
            tx_msb_first <= txf_act_r[FRM_MSB_BIT];
            rx_msb_first <= rxf_act_r[FRM_MSB_BIT];
        end
    end

    // Shift registers held clear whenever the block is not running
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            tx_shift_clr <= 1'b1;
            rx_shift_clr <= 1'b1;
        end
        else
        begin
            tx_shift_clr <= txq_r[Q_CLEAR_BIT] || state_r != ST_RUN;
            rx_shift_clr <= rxq_r[Q_CLEAR_BIT] || state_r != ST_RUN;
        end
    end

    // Trigger levels trail the counts by one cycle
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            tx_trigger <= 1'b0;
            rx_trigger <= 1'b0;
        end
        else
        begin
            tx_trigger <= tx_trig_nxt;
            rx_trigger <= rx_trig_nxt;
        end
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            irq_stat_r <= 2'h0;
            irq        <= 1'b0;
        end
        else
        begin
            if (wr_acc && ofs == OFS_IRQ_STAT && wb_sel_i[0])
            begin
                irq_stat_r <= (irq_stat_r & ~wb_dat_i[1:0]) | irq_set;
            end
            else
            begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
            irq <= |(irq_stat_r & irq_mask_r & IRQ_BITS);
        end
    end

    // ------------------------------------------------------------
    // Wishbone read and acknowledge
    // ------------------------------------------------------------
    always_comb
    begin
        rd_nxt = 32'h0;
        case (ofs)
            OFS_MAIN_CTRL: rd_nxt = main_r;
            OFS_SPI_CTRL:  rd_nxt = spi_r;
            OFS_TX_CTRL:   rd_nxt = txf_r;
            OFS_RX_CTRL:   rd_nxt = rxf_r;
            OFS_TXQ_CTRL:  rd_nxt = txq_r;
            OFS_RXQ_CTRL:  rd_nxt = rxq_r;
            OFS_STATUS:    rd_nxt = {state_r == ST_RUN, 15'h0, 4'h0, q_cnt[1], 4'h0, q_cnt[0]};
            OFS_IRQ_STAT:  rd_nxt = {30'h0, irq_stat_r};
            OFS_IRQ_MASK:  rd_nxt = {30'h0, irq_mask_r};
            default:       rd_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= rd_acc && hit;
            wb_err_o <= rd_acc && !hit;
            wb_dat_o <= (rd_acc && hit && !wb_we_i) ? rd_nxt : 32'h0;
        end
    end
endmodule // scc_top

// File: sim/scc_far_model.sv
// Far-side model: shifter push and pop pulses and the serial input pin
`timescale 1ns/1ns
module scc_far_model (
    input  wire logic   clk_sys,
    output logic        tx_push,
    output logic [15:0] tx_push_data,
    output logic        tx_pop,
    output logic        rx_push,
    output logic [15:0] rx_push_data,
    output logic        rx_pop,
    output logic        line_in
);
    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    initial
    begin
        {rx_pop, rx_push, tx_pop, tx_push, line_in} = 5'h0;
        tx_push_data = 16'h0;
        rx_push_data = 16'hFFFF;
    end
    // Mask {rx_pop, rx_push, tx_pop, tx_push}; payload changes every cycle
    task automatic pulse(input logic [3:0] m, input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            {rx_pop, rx_push, tx_pop, tx_push} <= m;
            tx_push_data <= tx_push_data + 16'h1;
            rx_push_data <= ~tx_push_data;
        end
        @(posedge clk_sys);
        {rx_pop, rx_push, tx_pop, tx_push} <= 4'h0;
    endtask
    // A hold of one cycle models a glitch on the pin
    task automatic drive_line(input logic v, input int n);
        @(posedge clk_sys);
        line_in <= v;
        repeat (n - 1) @(posedge clk_sys);
    endtask
endmodule // scc_far_model

// File: sim/scc_top_asserts.sv
// Checker: bus handshake and configuration hold assertions
`timescale 1ns/1ns
module scc_top_asserts (
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic [31:0] wb_adr_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        active_spi,
    input wire logic        role_master,
    input wire logic [1:0]  sub_format,
    input wire logic [3:0]  tx_bits_m1,
    input wire logic [3:0]  rx_bits_m1,
    input wire logic        tx_shift_clr,
    input wire logic        rx_shift_clr,
    input wire logic        rx_trigger
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_run2;
        active_spi ##1 active_spi;
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_ack_next: assert property (s_req |=> wb_ack_o != wb_err_o)
        else $error("request not answered once");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_err_misalign: assert property (s_req ##0 (wb_adr_i[1:0] != 2'h0) |=> wb_err_o)
        else $error("misaligned access not refused");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_rst_off: assert property (disable iff (1'b0) srst |=>
        !active_spi && tx_shift_clr && rx_shift_clr && tx_bits_m1 == 4'h3)
        else $error("reset state wrong");
    // Config outputs come from the copy latched at enable
    chk_cfg_hold: assert property (s_run2 |->
        $stable({role_master, sub_format, tx_bits_m1, rx_bits_m1}))
        else $error("config moved while running");
    chk_width_min: assert property (tx_bits_m1 >= 4'h3 && rx_bits_m1 >= 4'h3)
        else $error("frame width below minimum");
    chk_clr_trig: assert property (rx_shift_clr [*3] |-> !rx_trigger)
        else $error("trigger while queue cleared");
    chk_fresh_en: assert property ($rose(active_spi) |-> !rx_trigger)
        else $error("queue not emptied at enable");
endmodule // scc_top_asserts

// File: sim/scc_top_tb.sv
// Testbench: register access, enable control, queue triggers and interrupt
`timescale 1ns/1ns
module scc_top_tb
    import scc_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic [3:0]  wb_sel_i = 4'h0, tx_bits_m1, rx_bits_m1;
    logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, wb_err_o, rerr;
    logic        line_filt, active_spi, role_master, tx_msb_first, rx_msb_first, irq;
    logic        tx_shift_clr, rx_shift_clr, tx_trigger, rx_trigger;
    logic        tx_push, tx_pop, rx_push, rx_pop, line_in;
    logic [1:0]  sub_format;
    logic [15:0] tx_push_data, rx_push_data;
    logic [17:0] cfg;
    int          miscompares = 0;
    int          compares = 0;
    always #50 clk_sys = ~clk_sys;
    assign cfg = {active_spi, role_master, sub_format, tx_bits_m1, rx_bits_m1, tx_msb_first,
                  rx_msb_first, tx_shift_clr, rx_shift_clr, tx_trigger, rx_trigger};
    scc_top dut (.clk_sys(clk_sys), .srst(srst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .tx_push(tx_push),
        .tx_push_data(tx_push_data), .tx_pop(tx_pop), .rx_push(rx_push),
        .rx_push_data(rx_push_data), .rx_pop(rx_pop), .line_in(line_in),
        .line_filt(line_filt), .active_spi(active_spi), .role_master(role_master),
        .sub_format(sub_format), .tx_bits_m1(tx_bits_m1), .rx_bits_m1(rx_bits_m1),
        .tx_msb_first(tx_msb_first), .rx_msb_first(rx_msb_first), .tx_shift_clr(tx_shift_clr),
        .rx_shift_clr(rx_shift_clr), .tx_trigger(tx_trigger), .rx_trigger(rx_trigger),
        .irq(irq));
    scc_far_model far (.clk_sys(clk_sys), .tx_push(tx_push), .tx_push_data(tx_push_data),
        .tx_pop(tx_pop), .rx_push(rx_push), .rx_push_data(rx_push_data), .rx_pop(rx_pop),
        .line_in(line_in));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic cycle: request held until ack or err is sampled
    task automatic wb(input logic [31:0] a, input logic [31:0] d, input logic w);
        @(posedge clk_sys);
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_we_i <= w;
        wb_sel_i <= 4'hF;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        @(posedge clk_sys);
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) @(posedge clk_sys);
        rdat = wb_dat_o;
        rerr = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        wb({26'h0, a}, d, 1'b1);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        wb({26'h0, a}, 32'h0, 1'b0);
        chk(rdat, exp);
    endtask
    // Sampling mid-cycle keeps checks clear of edge updates
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic complete_run();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        miscompares++;
        complete_run();
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        wt(1);
        chk(cfg, {2'h0, 2'h0, 4'h3, 4'h3, 4'h3, 2'h0});
        rd(OFS_MAIN_CTRL, MAIN_RST);
        rd(OFS_RX_CTRL, FRM_RST);
        rd(OFS_RXQ_CTRL, Q_RST);
        wb(32'h24, 32'h0, 1'b0);
        chk(rerr, 1'b1);
        wb(32'h2, 32'h0, 1'b0);
        chk(rerr, 1'b1);
        wr(OFS_SPI_CTRL, 32'h8000_0020);
        wr(OFS_TX_CTRL, 32'h0000_000F);
        wr(OFS_RX_CTRL, 32'h0000_0305);
        wr(OFS_TXQ_CTRL, 32'h0000_0003);
        wr(OFS_RXQ_CTRL, 32'h0000_0002);
        wr(OFS_MAIN_CTRL, 32'h0100_0000);
        wr(OFS_MAIN_CTRL, 32'h8100_0000);
        wt(4);
        chk(cfg, {2'h3, 2'h2, 4'hF, 4'h5, 4'h4, 2'h2});
        wr(OFS_SPI_CTRL, 32'hFFFF_FFFF);
        rd(OFS_SPI_CTRL, SPI_MASK);
        wt(3);
        chk(cfg, {2'h3, 2'h2, 4'hF, 4'h5, 4'h4, 2'h2});
        wr(OFS_IRQ_MASK, 32'h1);
        wt(2);
        chk(irq, 1'b1);
        far.pulse(4'h5, 3);
        wt(2);
        rd(OFS_STATUS, 32'h8000_0303);
        chk(cfg[1:0], 2'h1);
        wr(OFS_IRQ_STAT, 32'h3);
        rd(OFS_IRQ_STAT, 32'h2);
        wt(2);
        chk(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h2);
        wt(2);
        chk(irq, 1'b1);
        wr(OFS_RXQ_CTRL, 32'h0002_0002);
        far.pulse(4'h4, 2);
        far.pulse(4'h8, 1);
        wt(2);
        rd(OFS_STATUS, 32'h8000_0303);
        far.pulse(4'h2, 5);
        wt(2);
        rd(OFS_STATUS, 32'h8000_0300);
        chk(cfg[1:0], 2'h3);
        wr(OFS_RXQ_CTRL, 32'h0001_0002);
        wt(3);
        chk(cfg[3:0], 4'h6);
        rd(OFS_STATUS, 32'h8000_0000);
        wr(OFS_RXQ_CTRL, 32'h0000_0002);
        far.pulse(4'h1, 2);
        wr(OFS_MAIN_CTRL, 32'h0100_0000);
        wt(3);
        chk(cfg[17], 1'b0);
        wr(OFS_MAIN_CTRL, 32'h8100_0000);
        wt(4);
        chk(cfg, {2'h3, 2'h3, 4'hF, 4'h5, 4'h4, 2'h2});
        rd(OFS_STATUS, 32'h8000_0000);
        for (int s = 0; s < 4; s++)
        begin
            wr(OFS_MAIN_CTRL, {6'h00, s[1:0], 24'h0});
            wr(OFS_MAIN_CTRL, {6'h20, s[1:0], 24'h0});
            wt(4);
            chk(cfg[17], s == 1);
        end
        far.drive_line(1'b1, 1);
        far.drive_line(1'b0, 1);
        repeat (6)
        begin
            wt(1);
            chk(line_filt, 1'b0);
        end
        far.drive_line(1'b1, 8);
        wt(1);
        chk(line_filt, 1'b1);
        wr(OFS_MAIN_CTRL, 32'h0100_0000);
        wr(OFS_TX_CTRL, 32'h0000_0001);
        rd(OFS_TX_CTRL, 32'h0000_0003);
        wr(OFS_RX_CTRL, 32'h0000_0105);
        wr(OFS_MAIN_CTRL, 32'h8100_0000);
        far.drive_line(1'b0, 1);
        far.drive_line(1'b1, 1);
        wt(4);
        chk(line_filt, 1'b0);
        wt(1);
        chk(line_filt, 1'b1);
        complete_run();
    end
endmodule // scc_top_tb
bind scc_top scc_top_asserts u_chk (.clk_sys(clk_sys), .srst(srst), .wb_adr_i(wb_adr_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .active_spi(active_spi), .role_master(role_master),
    .sub_format(sub_format), .tx_bits_m1(tx_bits_m1), .rx_bits_m1(rx_bits_m1),
    .tx_shift_clr(tx_shift_clr), .rx_shift_clr(rx_shift_clr), .rx_trigger(rx_trigger));
